/* File: dv/mfp_inverter_model.sv */
`timescale 1ns/1ps
`default_nettype none

module mfp_inverter_model (
  // Clock
  input wire logic clk,
  // Gate drive from the block
  input wire logic [2:0] hs,
  input wire logic [2:0] ls,
  input wire logic oe,
  // Commands from the bench
  input wire logic [15:0] edge_period,
  input wire logic shunt_short,
  // Feedback to the block
  output logic elec_edge,
  output logic oc_detect
);
  // ==========================================================
  // Rotor and shunt
  logic [15:0] cnt = 16'h0000;
  logic spin;

  // The rotor only turns while a high-side switch is driven.
  // Shunt current also needs a low-side return path, so the
  // comparator falls silent once the gates are switched off.
  assign spin = oe && (|hs);
  assign oc_detect = shunt_short && spin && (|ls);
  assign elec_edge = spin && (edge_period != 16'h0000) &&
                     (cnt == edge_period - 16'h0001);

  always @(posedge clk) begin
    if (!spin || edge_period == 16'h0000) begin
      cnt <= 16'h0000;
    end else if (cnt >= edge_period - 16'h0001) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule : mfp_inverter_model

`default_nettype wire

/* File: dv/mfp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module mfp_top_tb;
  import mfp_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [2:0] DHS = 3'b101;
  localparam logic [2:0] DLS = 3'b010;
  localparam logic [15:0] LATCH = 16'h0001 << MFP_F_LATCH;
  logic clk = 1'b0, rst_n = 1'b0, apol = 1'b0, ok;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awr, wr, bv, arr, rv, edge_p, ocd, gate_oe, run, ocref, al_o, al_oe;
  logic [1:0] bresp, rresp, r;
  logic uvm = 1'b0, uvr = 1'b0, pump = 1'b0, hot = 1'b0, standby_request = 1'b0;
  logic short_c = 1'b0, fround = 1'b0, sless = 1'b0, szero = 1'b0;
  logic [2:0] hs, ls;
  logic [15:0] period = 16'h0000;
  int bad_count = 0;
  int n_compared = 0;

  always #12.5 clk = ~clk;

  mfp_top #(.CYC_PER_US(1)) i_mfp_top (
    .REF_CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .MOTOR_SUPPLY_UV(uvm), .REGULATOR_SUPPLY_UV(uvr),
    .OVERCURRENT_DETECT(ocd), .PUMP_HEADROOM_LOW_DETECT(pump),
    .JUNCTION_TEMPERATURE_HIGH(hot), .STANDBY_REQUEST(standby_request),
    .DRIVE_HS(DHS), .DRIVE_LS(DLS), .ELEC_EDGE(edge_p),
    .FORCED_ROUND(fround), .SENSORLESS(sless), .SPEED_ZERO(szero),
    .HIGH_SIDE_GATE_OUTPUTS(hs), .LOW_SIDE_GATE_OUTPUTS(ls),
    .GATE_OE(gate_oe), .RUN_ENABLE(run), .OVERCURRENT_REF_SEL(ocref),
    .ALERT_O(al_o), .ALERT_OE(al_oe));

  mfp_inverter_model i_mfp_inverter_model (.clk(clk), .hs(hs), .ls(ls),
    .oe(gate_oe), .edge_period(period), .shunt_short(short_c),
    .elec_edge(edge_p), .oc_detect(ocd));

  // ==========================================================
  // Bus and check tasks
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  // Ready is decided between edges, so the payload drops at the edge.
  task automatic axw(input logic [7:0] a, input logic [31:0] dv,
                     output logic [1:0] rs);
    logic ta, tw;
    @(posedge clk);
    awaddr <= {24'h000000, a};
    wdata <= dv;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (awv || wv);
    do @(negedge clk); while (!bv);
    rs = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] dv,
                     output logic [1:0] rs);
    @(posedge clk);
    araddr <= {24'h000000, a};
    arv <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (!rv);
    dv = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : axr

  task automatic look(input string nm, input logic rn, input logic oe,
                      input logic [2:0] eh, input logic [2:0] el,
                      input logic [5:0] st);
    chk({nm, " run"}, rn, run);
    chk({nm, " oe"}, oe, gate_oe);
    chk({nm, " alert"}, rn ^ apol, al_oe);
    chk({nm, " alert pin"}, 1'b0, al_o);
    if (oe) begin
      chk({nm, " high"}, eh, hs);
      chk({nm, " low"}, el, ls);
    end
    axr(MFP_OFS_STATUS, d, r);
    chk({nm, " status"}, st, d & 32'h3f);
  endtask : look

  task automatic set_src(input int s, input logic v);
    case (s)
      0: short_c <= v;
      1: pump <= v;
      2: hot <= v;
      default: uvm <= v;
    endcase
  endtask : set_src

  task automatic fcase(input string nm, input logic [15:0] c, input int s,
                       input logic rn, input logic [5:0] st);
    axw(MFP_OFS_CTRL, {16'h0000, c}, r);
    set_src(s, 1'b1);
    settle(8);
    look(nm, rn, s != 1 || rn, rn ? DHS : 3'h0, rn ? DLS : 3'h0, st);
    set_src(s, 1'b0);
    settle(8);
    if (!rn && c[MFP_F_LATCH +: 4] != 4'h0) begin
      chk({nm, " held"}, 1'b0, run);
      szero <= 1'b1;
      settle(2);
      szero <= 1'b0;
      settle(4);
    end
    look({nm, " recovered"}, 1'b1, 1'b1, DHS, DLS, st);
    axw(MFP_OFS_STATUS, 32'h3f, r);
    look({nm, " cleared"}, 1'b1, 1'b1, DHS, DLS, 6'h00);
    $display("test %s done", nm);
  endtask : fcase

  task automatic standby_cycle(input string nm);
    standby_request <= 1'b1;
    settle(6);
    chk({nm, " standby oe"}, 1'b0, gate_oe);
    standby_request <= 1'b0;
    settle(6);
    look({nm, " restart"}, 1'b1, 1'b1, DHS, DLS, 6'h00);
  endtask : standby_cycle

  task automatic start(input string nm, input logic [15:0] c,
                       input logic rn, input logic [2:0] el);
    axw(MFP_OFS_CTRL, {16'h0000, c}, r);
    repeat (4) begin
      chk({nm, " before"}, 1'b1, run);
      fround <= 1'b1;
      @(posedge clk);
      fround <= 1'b0;
      settle(4);
    end
    look(nm, rn, 1'b1, rn ? DHS : 3'h0, el, rn ? 6'h00 : 6'h01);
    standby_cycle(nm);
    $display("test %s done", nm);
  endtask : start

  task automatic complete_run;
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // Tests
  initial begin
    settle(6);
    rst_n <= 1'b1;
    settle(2);
    axr(MFP_OFS_CTRL, d, r);
    chk("ctrl reset", {16'h0000, MFP_CTRL_RST}, d);
    axr(8'h3c, d, r);
    chk("unmapped read", MFP_RESP_SLVERR, r);
    axw(8'h3c, 32'h0000ffff, r);
    chk("unmapped write", MFP_RESP_SLVERR, r);
    axw(MFP_OFS_CTRL, 32'h1 << MFP_F_OCREF, r);
    settle(2);
    chk("ref select", 1'b1, ocref);
    look("normal", 1'b1, 1'b1, DHS, DLS, 6'h00);
    $display("test registers done");
    fcase("overcurrent", LATCH, 0, 1'b0, 6'h08);
    fcase("oc masked", LATCH | 16'h0080, 0, 1'b1, 6'h00);
    fcase("pump low", LATCH, 1, 1'b0, 6'h20);
    fcase("pump masked", 16'h0100, 1, 1'b1, 6'h00);
    fcase("thermal", 16'h0000, 2, 1'b0, 6'h10);
    fcase("thermal delayed", 16'h0800, 2, 1'b0, 6'h10);
    fcase("thermal masked", 16'h0200, 2, 1'b1, 6'h00);
    apol = 1'b1;
    fcase("motor uv", 16'h4000, 3, 1'b0, 6'h00);
    apol = 1'b0;
    uvr <= 1'b1;
    settle(8);
    chk("regulator uv", 1'b0, run);
    uvm <= 1'b1;
    uvr <= 1'b0;
    settle(8);
    chk("one supply low", 1'b0, run);
    uvm <= 1'b0;
    settle(8);
    chk("both released", 1'b1, run);
    start("stall brake", LATCH | 16'h0010, 1'b0, 3'h7);
    start("stall off", LATCH, 1'b0, 3'h0);
    start("start disabled", 16'h0020, 1'b1, DLS);
    sless <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      ok = (k > 1);
      axw(MFP_OFS_CTRL, {16'h0000, LATCH} | k, r);
      period <= 16'd400;
      settle(2000);
      look("over speed", ok, 1'b1, ok ? DHS : 3'h0, ok ? DLS : 3'h0,
           ok ? 6'h00 : 6'h04);
      period <= 16'h0000;
      standby_cycle("over speed");
    end
    sless <= 1'b0;
    complete_run();
  end

  initial begin
    settle(60000);
    bad_count++;
    complete_run();
  end
endmodule : mfp_top_tb

`default_nettype wire

/* File: rtl/mfp_axil.sv */
`timescale 1ns/1ps
`default_nettype none

module mfp_axil (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write channels
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  mfp_reg_if.bus rg
);
  import mfp_pkg::*;

  typedef struct packed {
    logic awok;
    logic wok;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mfp_axil_t;

  mfp_axil_t r;
  mfp_axil_t next_r;

  // Address and data are taken in either order; the write is
  // applied once both are held, so bvalid follows both.
  assign awready = !r.awok && !r.bvalid;
  assign wready = !r.wok && !r.bvalid;
  assign arready = !r.rvalid;
  assign rg.wr = r.awok && r.wok;
  assign rg.waddr = r.addr;
  assign rg.wdata = r.data;
  assign rg.wstrb = r.strb;
  assign rg.rd = arvalid && arready;
  assign rg.raddr = araddr[7:0];

  always_comb begin
    next_r = r;
    if (awvalid && awready) begin
      next_r.awok = 1'b1;
      next_r.addr = awaddr[7:0];
    end
    if (wvalid && wready) begin
      next_r.wok = 1'b1;
      next_r.data = wdata;
      next_r.strb = wstrb;
    end
    if (rg.wr) begin
      next_r.awok = 1'b0;
      next_r.wok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = rg.werr ? MFP_RESP_SLVERR : MFP_RESP_OKAY;
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    if (rg.rd) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rg.rdata;
      next_r.rresp = rg.rerr ? MFP_RESP_SLVERR : MFP_RESP_OKAY;
    end else if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;

endmodule : mfp_axil

`default_nettype wire

/* File: rtl/mfp_pkg.sv */
package mfp_pkg;

  // ==========================================================
  // Register map and fields
  localparam logic [7:0] MFP_OFS_STATUS = 8'h00;
  localparam logic [7:0] MFP_OFS_CTRL = 8'h04;
  localparam logic [7:0] MFP_OFS_MON = 8'h08;
  localparam logic [15:0] MFP_CTRL_RST = 16'h0000;
  localparam int MFP_F_MAXSEL = 0;
  localparam int MFP_F_FCSEL = 2;
  localparam int MFP_F_BRAKE = 4;
  localparam int MFP_F_STDIS = 5;
  localparam int MFP_F_OCREF = 6;
  localparam int MFP_F_OCMASK = 7;
  localparam int MFP_F_PUMPDIS = 8;
  localparam int MFP_F_TMASK = 9;
  localparam int MFP_F_LATCH = 10;
  localparam int MFP_F_RESTART = 11;
  localparam int MFP_F_ALPOL = 14;
  localparam int MFP_B_STFAIL = 0;
  localparam int MFP_B_UDSPD = 1;
  localparam int MFP_B_OVSPD = 2;
  localparam int MFP_B_OCP = 3;
  localparam int MFP_B_HOT = 4;
  localparam int MFP_B_PUMP = 5;
  localparam logic [1:0] MFP_RESP_OKAY = 2'h0;
  localparam logic [1:0] MFP_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Timing
  localparam int MFP_CLK_MHZ = 40;
  localparam int MFP_MAX_HZ [0:2] = '{750, 1500, 3000};
  // Periods of 1.6, 3.2, 6.4 and 12.8 Hz.
  localparam int MFP_FC_PERIOD_US [0:3] = '{625000, 312500, 156250, 78125};
  localparam int MFP_RESTART_MS [0:7] =
    '{0, 500, 1000, 1500, 2000, 4000, 7000, 10000};
  localparam logic [2:0] MFP_START_ROUNDS = 3'h4;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MFP_RUN = 2'b00,
    MFP_ERR = 2'b01,
    MFP_STANDBY_REQUEST = 2'b10,
    MFP_UV = 2'b11
  } mfp_state_t;

  typedef enum logic [1:0] {
    MFP_ACT_OFF = 2'b00,
    MFP_ACT_BRAKE = 2'b01,
    MFP_ACT_HIZ = 2'b10
  } mfp_act_t;

endpackage : mfp_pkg

/* File: rtl/mfp_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface mfp_reg_if;
  logic wr;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic werr;
  logic rd;
  logic [7:0] raddr;
  logic [31:0] rdata;
  logic rerr;
  modport bus (output wr, waddr, wdata, wstrb, rd, raddr,
               input werr, rdata, rerr);
  modport regs (input wr, waddr, wdata, wstrb, rd, raddr,
                output werr, rdata, rerr);
endinterface : mfp_reg_if

`default_nettype wire

/* File: rtl/mfp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module mfp_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } mfp_sync_t;

  mfp_sync_t r;
  mfp_sync_t next_r;

  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule : mfp_sync

`default_nettype wire

/* File: rtl/mfp_top.sv */
`timescale 1ns/1ps
`default_nettype none

module mfp_top #(
  parameter int unsigned CYC_PER_US = mfp_pkg::MFP_CLK_MHZ
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // AXI4-Lite slave
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Asynchronous comparator flags and standby pin
  input wire logic MOTOR_SUPPLY_UV,
  input wire logic REGULATOR_SUPPLY_UV,
  input wire logic OVERCURRENT_DETECT,
  input wire logic PUMP_HEADROOM_LOW_DETECT,
  input wire logic JUNCTION_TEMPERATURE_HIGH,
  input wire logic STANDBY_REQUEST,
  // Commutation logic
  input wire logic [2:0] DRIVE_HS,
  input wire logic [2:0] DRIVE_LS,
  input wire logic ELEC_EDGE,
  input wire logic FORCED_ROUND,
  input wire logic SENSORLESS,
  input wire logic SPEED_ZERO,
  // Gate drive and status pins
  output logic [2:0] HIGH_SIDE_GATE_OUTPUTS,
  output logic [2:0] LOW_SIDE_GATE_OUTPUTS,
  output logic GATE_OE,
  output logic RUN_ENABLE,
  output logic OVERCURRENT_REF_SEL,
  output logic ALERT_O,
  output logic ALERT_OE
);
  import mfp_pkg::*;

  // ==========================================================
  // Derived cycle counts
  localparam int unsigned OVS_CYC [0:2] = '{
    CYC_PER_US * 1000000 / MFP_MAX_HZ[0],
    CYC_PER_US * 1000000 / MFP_MAX_HZ[1],
    CYC_PER_US * 1000000 / MFP_MAX_HZ[2]};
  localparam int unsigned FC_CYC [0:3] = '{
    CYC_PER_US * MFP_FC_PERIOD_US[0],
    CYC_PER_US * MFP_FC_PERIOD_US[1],
    CYC_PER_US * MFP_FC_PERIOD_US[2],
    CYC_PER_US * MFP_FC_PERIOD_US[3]};
  localparam int unsigned CYC_PER_MS = CYC_PER_US * 1000;
  localparam int unsigned RESTART_CYC [0:7] = '{
    CYC_PER_MS * MFP_RESTART_MS[0], CYC_PER_MS * MFP_RESTART_MS[1],
    CYC_PER_MS * MFP_RESTART_MS[2], CYC_PER_MS * MFP_RESTART_MS[3],
    CYC_PER_MS * MFP_RESTART_MS[4], CYC_PER_MS * MFP_RESTART_MS[5],
    CYC_PER_MS * MFP_RESTART_MS[6], CYC_PER_MS * MFP_RESTART_MS[7]};

  typedef struct packed {
    mfp_state_t state;
    mfp_act_t act;
    logic [31:0] cyc;
    logic [31:0] tmr;
    logic [2:0] rounds;
    logic [5:0] flags;
    logic [15:0] ctrl;
    logic [2:0] hs;
    logic [2:0] ls;
    logic oe;
    logic alert_oe;
  } mfp_core_t;

  mfp_core_t r;
  mfp_core_t next_r;
  logic [5:0] sy;
  mfp_reg_if rg ();

  // ==========================================================
  // Bus slave and synchronisers
  mfp_axil u_axil (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rg(rg.bus)
  );

  // Every comparator flag is slow and asynchronous.
  mfp_sync #(.WIDTH(6)) u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d({STANDBY_REQUEST, JUNCTION_TEMPERATURE_HIGH,
        PUMP_HEADROOM_LOW_DETECT, OVERCURRENT_DETECT,
        REGULATOR_SUPPLY_UV, MOTOR_SUPPLY_UV}),
    .q(sy)
  );

  // ==========================================================
  // Control fields and conditions
  logic [1:0] max_speed_limit_sel;
  logic [1:0] forced_commutation_rate_sel;
  logic stall_action_brake_sel;
  logic startup_fail_disable;
  logic overcurrent_mask;
  logic pump_low_disable;
  logic thermal_mask;
  logic latch_sel;
  logic [2:0] restart_delay_sel;
  logic alert_low_sel;
  logic uv_any;
  logic standby_request;
  logic ocp_t;
  logic pump_t;
  logic hot_t;
  logic running;
  logic ovs;
  logic uds;
  logic stf;
  logic cond_clear;
  logic [5:0] causes;
  logic [31:0] ovs_lim;
  logic [31:0] fc_lim;
  logic [31:0] rst_lim;

  assign max_speed_limit_sel = r.ctrl[MFP_F_MAXSEL +: 2];
  assign forced_commutation_rate_sel = r.ctrl[MFP_F_FCSEL +: 2];
  assign stall_action_brake_sel = r.ctrl[MFP_F_BRAKE];
  assign startup_fail_disable = r.ctrl[MFP_F_STDIS];
  assign overcurrent_mask = r.ctrl[MFP_F_OCMASK];
  assign pump_low_disable = r.ctrl[MFP_F_PUMPDIS];
  assign thermal_mask = r.ctrl[MFP_F_TMASK];
  assign latch_sel = r.ctrl[MFP_F_LATCH];
  assign restart_delay_sel = r.ctrl[MFP_F_RESTART +: 3];
  assign alert_low_sel = r.ctrl[MFP_F_ALPOL];

  assign uv_any = sy[0] || sy[1];
  assign ocp_t = sy[2] && !overcurrent_mask;
  assign pump_t = sy[3] && !pump_low_disable;
  assign hot_t = sy[4] && !thermal_mask;
  assign standby_request = sy[5];
  assign running = (r.state == MFP_RUN);

  assign ovs_lim = (max_speed_limit_sel == 2'h3) ? 32'h0 :
                   32'(OVS_CYC[max_speed_limit_sel]);
  assign fc_lim = 32'(FC_CYC[forced_commutation_rate_sel]);
  assign rst_lim = 32'(RESTART_CYC[restart_delay_sel]);

  // A period of cyc+1 cycles at or under the limit is a frequency
  // at or over the maximum; selector 11 never matches.
  assign ovs = running && SENSORLESS && ELEC_EDGE && (r.cyc < ovs_lim);
  // No electrical edge within one forced commutation period means
  // the rotor is slower than that rate, stalled included.
  assign uds = running && SENSORLESS && (r.cyc >= fc_lim);
  assign stf = running && !SENSORLESS && FORCED_ROUND &&
               !startup_fail_disable &&
               (r.rounds == MFP_START_ROUNDS - 3'h1);
  assign causes = {pump_t, hot_t, ocp_t, ovs, uds, stf};
  assign cond_clear = !ocp_t && !hot_t && !pump_t;

  // ==========================================================
  // Register access
  always_comb begin
    rg.werr = !(rg.waddr inside {MFP_OFS_STATUS, MFP_OFS_CTRL,
                                 MFP_OFS_MON});
    rg.rerr = 1'b0;
    case (rg.raddr)
      MFP_OFS_STATUS: rg.rdata = {26'h0, r.flags};
      MFP_OFS_CTRL: rg.rdata = {16'h0, r.ctrl};
      MFP_OFS_MON: rg.rdata = {19'h0, r.rounds, sy, r.act, r.state};
      default: begin
        rg.rdata = 32'h0;
        rg.rerr = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Fault engine
  always_comb begin
    next_r = r;
    if (ELEC_EDGE) begin
      next_r.cyc = 32'h0;
    end else if (r.cyc != 32'hffffffff) begin
      next_r.cyc = r.cyc + 32'h1;
    end
    if (!running || SENSORLESS) begin
      next_r.rounds = 3'h0;
    end else if (FORCED_ROUND && r.rounds != MFP_START_ROUNDS) begin
      next_r.rounds = r.rounds + 3'h1;
    end
    if (r.tmr != 32'hffffffff) begin
      next_r.tmr = r.tmr + 32'h1;
    end
    if (rg.wr && rg.waddr == MFP_OFS_CTRL) begin
      if (rg.wstrb[0]) next_r.ctrl[7:0] = rg.wdata[7:0];
      if (rg.wstrb[1]) next_r.ctrl[15:8] = rg.wdata[15:8];
    end
    if (rg.wr && rg.waddr == MFP_OFS_STATUS && rg.wstrb[0]) begin
      next_r.flags = r.flags & ~rg.wdata[5:0];
    end
    if (standby_request) begin
      next_r.flags = 6'h0;
    end
    // A detection in the same cycle as a clear keeps its flag.
    if (running) begin
      next_r.flags = next_r.flags | causes;
    end

    case (r.state)
      MFP_RUN: begin
        if (|causes) begin
          next_r.state = MFP_ERR;
          next_r.tmr = 32'h0;
          if (pump_t) begin
            next_r.act = MFP_ACT_HIZ;
          end else if (hot_t || ocp_t || ovs) begin
            next_r.act = MFP_ACT_OFF;
          end else begin
            next_r.act = stall_action_brake_sel ? MFP_ACT_BRAKE :
                                                  MFP_ACT_OFF;
          end
        end
      end
      MFP_ERR: begin
        // The source must be gone before either way out.
        if (cond_clear && (SPEED_ZERO ||
            (!latch_sel && r.tmr >= rst_lim))) begin
          next_r.state = MFP_RUN;
        end
      end
      MFP_UV: begin
        if (!uv_any) next_r.state = MFP_RUN;
      end
      MFP_STANDBY_REQUEST: begin
        if (!standby_request) next_r.state = MFP_RUN;
      end
      default: next_r.state = MFP_RUN;
    endcase
    // Standby outranks undervoltage, which outranks any error.
    if (standby_request) begin
      next_r.state = MFP_STANDBY_REQUEST;
    end else if (uv_any) begin
      next_r.state = MFP_UV;
    end
    if (next_r.state == MFP_RUN && r.state != MFP_RUN) begin
      next_r.cyc = 32'h0;
      next_r.rounds = 3'h0;
    end

    // Gates follow the next state, so each change shows one edge
    // after its cause.
    next_r.hs = 3'h0;
    next_r.ls = 3'h0;
    next_r.oe = 1'b1;
    case (next_r.state)
      MFP_RUN: begin
        next_r.hs = DRIVE_HS;
        next_r.ls = DRIVE_LS;
      end
      MFP_ERR: begin
        if (next_r.act == MFP_ACT_BRAKE) next_r.ls = 3'h7;
        if (next_r.act == MFP_ACT_HIZ) next_r.oe = 1'b0;
      end
      MFP_STANDBY_REQUEST: next_r.oe = 1'b0;
      default: next_r.oe = 1'b1;
    endcase
    // The pin can only pull low; the pull-up gives the high level.
    next_r.alert_oe = alert_low_sel ==
                      (next_r.state inside {MFP_ERR, MFP_UV});
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      r <= '{state: MFP_RUN, act: MFP_ACT_OFF, ctrl: MFP_CTRL_RST,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign HIGH_SIDE_GATE_OUTPUTS = r.hs;
  assign LOW_SIDE_GATE_OUTPUTS = r.ls;
  assign GATE_OE = r.oe;
  assign RUN_ENABLE = running;
  assign OVERCURRENT_REF_SEL = r.ctrl[MFP_F_OCREF];
  assign ALERT_O = 1'b0;
  assign ALERT_OE = r.alert_oe;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_free;
    !standby_request && !uv_any;
  endsequence
  sequence s_stall;
    s_free and (running && (uds || stf) && !pump_t && !hot_t &&
                !ocp_t && !ovs);
  endsequence
  sequence s_off;
    HIGH_SIDE_GATE_OUTPUTS == 3'h0 && GATE_OE;
  endsequence

  a_uv_halt: assert property (uv_any && !standby_request |=>
    (r.state == MFP_UV) and s_off and (LOW_SIDE_GATE_OUTPUTS == 3'h0))
    else $error("undervoltage did not halt");
  a_uv_release: assert property (
    r.state == MFP_UV ##1 ((r.state == MFP_UV) and s_free) |=> running)
    else $error("undervoltage release missed");
  a_standby_request_hiz: assert property (standby_request |=> !GATE_OE &&
    r.state == MFP_STANDBY_REQUEST)
    else $error("standby handling wrong");
  a_standby_request_exit: assert property (r.state == MFP_STANDBY_REQUEST &&
    !standby_request && !uv_any |=> running)
    else $error("standby release missed");
  a_ocp_off: assert property (s_free and (running && ocp_t &&
    !pump_t) |=> (r.state == MFP_ERR) and s_off and
    (LOW_SIDE_GATE_OUTPUTS == 3'h0))
    else $error("overcurrent not shut off");
  a_pump_hiz: assert property (s_free and (running && pump_t)
    |=> !GATE_OE)
    else $error("pump low not high impedance");
  a_pump_hold: assert property (r.state == MFP_ERR &&
    r.act == MFP_ACT_HIZ && pump_t && !uv_any |=> !GATE_OE)
    else $error("pump low released too early");
  a_hot_off: assert property (s_free and (running && hot_t &&
    !pump_t) |=> (r.state == MFP_ERR) and s_off)
    else $error("thermal not shut off");
  a_ovs_off: assert property (s_free and (ovs && !pump_t)
    |=> (r.flags[MFP_B_OVSPD]) and s_off and
    (LOW_SIDE_GATE_OUTPUTS == 3'h0))
    else $error("over-speed not shut off");
  a_stall_act: assert property (s_stall |=> s_off and
    (LOW_SIDE_GATE_OUTPUTS == {3{$past(stall_action_brake_sel)}}))
    else $error("stall action wrong");
  a_stfail_dis: assert property (startup_fail_disable &&
    !r.flags[MFP_B_STFAIL] && !(rg.wr) |=> !r.flags[MFP_B_STFAIL])
    else $error("startup failure raised while disabled");
  a_latch_hold: assert property (r.state == MFP_ERR &&
    latch_sel && !SPEED_ZERO && s_free |=> r.state == MFP_ERR)
    else $error("latched error left without release");
  a_alert_pol: assert property (RST_N |=> ALERT_OE ==
    (alert_low_sel == (r.state inside {MFP_ERR, MFP_UV})) ||
    $changed(alert_low_sel))
    else $error("alert level wrong");

endmodule : mfp_top

`default_nettype wire
